// ### hw/dbs_burst_map.sv
// burst counter seed and internal word address mapping per organisation
`timescale 1ns/100ps
`include "dbs_defs.svh"

module dbs_burst_map
  import dbs_pkg::*;
(
  // address mapping link
  dbs_addr_if.mapper am
);

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------

  // one-bit linear counter: second beat flips the seed bit
  always_comb
  begin
    unique case (am.org)
      `DBS_ORG_CODE_X8:
      begin
        // lowest internal bit forced low, bursts always start at word zero
        am.beat0_addr = {am.raw_addr, 1'b0}; // [R02]
        am.beat1_addr = {am.raw_addr, 1'b1}; // [R02]
      end
      `DBS_ORG_CODE_X18:
      begin
        // twenty lines, seed bit loaded into the counter
        am.beat0_addr = {1'b0, am.raw_addr}; // [R03] [R04]
        am.beat1_addr = {1'b0, am.raw_addr[`DBS_ADDR_W-1:1], ~am.raw_addr[0]}; // [R03]
      end
      default:
      begin
        // x36 and the unused strap code: top line is not decoded
        am.beat0_addr = {2'b00, am.raw_addr[`DBS_X36_ADDR_LINES-1:0]}; // [R04]
        am.beat1_addr = {2'b00, am.raw_addr[`DBS_X36_ADDR_LINES-1:1], ~am.raw_addr[0]}; // [R03]
      end
    endcase
  end

endmodule // dbs_burst_map

// ### hw/dbs_sram_port.sv
// burst sram port: address load, direction, ddr capture and read launch
// Notes on behaviour
// R01: one address bus serves reads and writes
// R02: x8 forces lowest internal bit to zero
// R03: x18/x36 seed counter from lowest address bit
// R04: x36 decodes nineteen lines, x18 twenty
// R05: address ignored while load strobe is high
// R06: direction high reads, low writes at load
// R07: read words launched on output clock pair
// R08: controller may deskew using output clocks
// R09: controls captured on positive input clock rise
// R10: write data also captured on negative rise
// R11: single clock mode launches on input clocks
// R12: each load moves exactly two data words
// R13: active-low byte masks gate each write word
// R14: outputs released when no read is active
`timescale 1ns/100ps
`include "dbs_defs.svh"

module dbs_sram_port
  import dbs_pkg::*;
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // input and output clock pins
  input  wire logic                   k_clk,
  input  wire logic                   k_clk_n,
  input  wire logic                   c_clk,
  input  wire logic                   c_clk_n,
  input  wire logic                   out_clk_present,
  // straps
  input  wire logic [`DBS_ORG_W-1:0]  org_sel,
  // command pins
  input  wire logic [`DBS_ADDR_W-1:0] addr_pin,
  input  wire logic                   load_strobe_n,
  input  wire logic                   rd_wr_dir,
  // data pins
  input  wire logic [`DBS_DATA_W-1:0] dq_in,
  input  wire logic [`DBS_MASK_W-1:0] byte_lane_mask_n,
  output logic      [`DBS_DATA_W-1:0] dq_out,
  output logic                        dq_oe
);

  // ----------------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------------
  localparam int PIN_W = 7 + `DBS_ORG_W + `DBS_ADDR_W + `DBS_DATA_W + `DBS_MASK_W;

  logic [PIN_W-1:0] pin_bus;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [3:0]       clk_prev_r;

  assign pin_bus = {k_clk, k_clk_n, c_clk, c_clk_n, out_clk_present, load_strobe_n, rd_wr_dir,
                    org_sel, addr_pin, dq_in, byte_lane_mask_n};

  // two stages for every pin; only the second stage feeds logic
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_bus;
      pin_s2_r <= pin_s1_r;
    end
  end

  // clock pin history for rise detection
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      clk_prev_r <= '0;
    else
      clk_prev_r <= pin_s2_r[PIN_W-1 -: 4];
  end

  // ----------------------------------------------------------------------------
  // unpacked synchronised pins
  // ----------------------------------------------------------------------------
  logic [3:0]             clk_now;
  logic                   out_present_s;
  logic                   load_n_s;
  logic                   dir_s;
  logic [`DBS_ORG_W-1:0]  org_s;
  logic [`DBS_ADDR_W-1:0] addr_s;
  dbs_data_t              din_s;
  logic [`DBS_MASK_W-1:0] mask_n_s;

  assign clk_now       = pin_s2_r[PIN_W-1 -: 4];
  assign out_present_s = pin_s2_r[PIN_W-5];
  assign load_n_s      = pin_s2_r[PIN_W-6];
  assign dir_s         = pin_s2_r[PIN_W-7];
  assign {org_s, addr_s, din_s, mask_n_s} = pin_s2_r[PIN_W-8:0];

  // rise of each clock pin seen in the mclk domain
  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  logic out_rise;
  logic out_n_rise;

  assign k_rise  = clk_now[3] & ~clk_prev_r[3]; // [R09]
  assign kn_rise = clk_now[2] & ~clk_prev_r[2]; // [R10]
  assign c_rise  = clk_now[1] & ~clk_prev_r[1];
  assign cn_rise = clk_now[0] & ~clk_prev_r[0];

  // launch edges: output pair when supplied, else the input pair
  assign out_rise   = out_present_s ? c_rise : k_rise;   // [R07] [R11]
  assign out_n_rise = out_present_s ? cn_rise : kn_rise; // [R07] [R11]

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------

  // bit enables from lane masks; an all-low mask gives the word width
  function automatic dbs_data_t lane_bits(input logic [`DBS_ORG_W-1:0] org,
                                          input logic [`DBS_MASK_W-1:0] m_n);
    dbs_data_t en;
    en = '0;
    unique case (org)
      `DBS_ORG_CODE_X8:
      begin
        en[`DBS_NIB_W-1:0]            = {`DBS_NIB_W{~m_n[0]}};
        en[2*`DBS_NIB_W-1:`DBS_NIB_W] = {`DBS_NIB_W{~m_n[1]}};
      end
      `DBS_ORG_CODE_X18:
      begin
        en[`DBS_LANE_W-1:0]             = {`DBS_LANE_W{~m_n[0]}};
        en[2*`DBS_LANE_W-1:`DBS_LANE_W] = {`DBS_LANE_W{~m_n[1]}};
      end
      default:
      begin
        for (int i = 0; i < `DBS_MASK_W; i++)
          en[i*`DBS_LANE_W +: `DBS_LANE_W] = {`DBS_LANE_W{~m_n[i]}};
      end
    endcase
    return en;
  endfunction

  // modelled array holds the low address bits only
  function automatic logic [`DBS_MEM_AW-1:0] mem_idx(input dbs_iaddr_t a);
    return a[`DBS_MEM_AW-1:0];
  endfunction

  // ----------------------------------------------------------------------------
  // burst address mapping
  // ----------------------------------------------------------------------------
  dbs_addr_if am ();

  assign am.raw_addr = addr_s; // [R01]
  assign am.org      = org_s;

  dbs_burst_map u_map
  (
    .am (am)
  );

  // ----------------------------------------------------------------------------
  // command load
  // ----------------------------------------------------------------------------
  logic       load_hit;
  dbs_iaddr_t wr_a0_r;
  dbs_iaddr_t wr_a1_r;
  logic       wr_cmd_r;
  dbs_iaddr_t rd_a0_r;
  dbs_iaddr_t rd_a1_r;
  logic       rd_cmd_r;

  // address and direction only count on a K rise with the strobe low
  assign load_hit = k_rise & ~load_n_s; // [R05] [R09] [R12]

  // shared bus: the loaded address goes to the slot its direction names
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wr_a0_r <= '0;
      wr_a1_r <= '0;
      rd_a0_r <= '0;
      rd_a1_r <= '0;
    end
    else if (load_hit)
    begin
      if (dir_s)
      begin
        rd_a0_r <= am.beat0_addr; // [R01] [R06]
        rd_a1_r <= am.beat1_addr;
      end
      else
      begin
        wr_a0_r <= am.beat0_addr; // [R01] [R06]
        wr_a1_r <= am.beat1_addr;
      end
    end
  end

  // write command waits for its first data word on the next K rise
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      wr_cmd_r <= 1'b0;
    else if (load_hit)
      wr_cmd_r <= ~dir_s; // [R06]
    else if (k_rise)
      wr_cmd_r <= 1'b0;
  end

  // read command waits for the next launch rise
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      rd_cmd_r <= 1'b0;
    else if (load_hit & dir_s)
      rd_cmd_r <= 1'b1; // [R06]
    else if (out_rise)
      rd_cmd_r <= 1'b0;
  end

  // ----------------------------------------------------------------------------
  // write data capture
  // ----------------------------------------------------------------------------
  dbs_data_t  mem [0:(1<<`DBS_MEM_AW)-1];
  logic       wr_hi_r;
  dbs_iaddr_t wr_hi_a_r;

  // second write beat armed by the first
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wr_hi_r   <= 1'b0;
      wr_hi_a_r <= '0;
    end
    else if (k_rise & wr_cmd_r)
    begin
      wr_hi_r   <= 1'b1; // [R12]
      wr_hi_a_r <= wr_a1_r;
    end
    else if (kn_rise)
      wr_hi_r <= 1'b0;
  end

  // masked lanes keep their old contents; array itself has no reset
  always_ff @(posedge mclk)
  begin
    if (k_rise & wr_cmd_r)
      mem[mem_idx(wr_a0_r)] <= (mem[mem_idx(wr_a0_r)] & ~lane_bits(org_s, mask_n_s)) |
                               (din_s & lane_bits(org_s, mask_n_s)); // [R09] [R13]
    else if (kn_rise & wr_hi_r)
      mem[mem_idx(wr_hi_a_r)] <= (mem[mem_idx(wr_hi_a_r)] & ~lane_bits(org_s, mask_n_s)) |
                                 (din_s & lane_bits(org_s, mask_n_s)); // [R10] [R13]
  end

  // ----------------------------------------------------------------------------
  // read data launch
  // ----------------------------------------------------------------------------
  logic       rd_hi_r;
  dbs_iaddr_t rd_hi_a_r;
  dbs_data_t  dq_out_r;
  logic       dq_oe_r;

  // second read beat armed by the first
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rd_hi_r   <= 1'b0;
      rd_hi_a_r <= '0;
    end
    else if (out_rise)
    begin
      rd_hi_r   <= rd_cmd_r; // [R12]
      rd_hi_a_r <= rd_a1_r;
    end
    else if (out_n_rise)
      rd_hi_r <= 1'b0;
  end

  // data held between launch rises; drive dropped on an idle rise
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      dq_out_r <= '0;
      dq_oe_r  <= 1'b0;
    end
    else if (out_rise)
    begin
      dq_oe_r <= rd_cmd_r; // [R14]
      if (rd_cmd_r)
        dq_out_r <= mem[mem_idx(rd_a0_r)] & lane_bits(org_s, '0); // [R07] [R11]
    end
    else if (out_n_rise & rd_hi_r)
      dq_out_r <= mem[mem_idx(rd_hi_a_r)] & lane_bits(org_s, '0); // [R07] [R11]
  end

  assign dq_out = dq_out_r;
  assign dq_oe  = dq_oe_r;

endmodule // dbs_sram_port

// ### include/dbs_addr_if.sv
// address mapping signals between the port logic and the burst mapper
`timescale 1ns/100ps
`include "dbs_defs.svh"

interface dbs_addr_if;
  import dbs_pkg::*;

  logic [`DBS_ADDR_W-1:0] raw_addr;
  logic [`DBS_ORG_W-1:0]  org;
  dbs_iaddr_t             beat0_addr;
  dbs_iaddr_t             beat1_addr;

  // port logic supplies pins, mapper returns both beat addresses
  modport user   (output raw_addr, output org, input beat0_addr, input beat1_addr);
  modport mapper (input raw_addr, input org, output beat0_addr, output beat1_addr);
endinterface

// ### include/dbs_defs.svh
// constants for the burst sram address, direction and clocking front end
`ifndef DBS_DEFS_SVH
`define DBS_DEFS_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define DBS_ADDR_W        20
`define DBS_IADDR_W       21
`define DBS_DATA_W        36
`define DBS_MASK_W        4
`define DBS_LANE_W        9
`define DBS_NIB_W         4
`define DBS_MEM_AW        10
`define DBS_ORG_W         2

// ----------------------------------------------------------------------------
// organisation codes
// ----------------------------------------------------------------------------
`define DBS_ORG_CODE_X8   2'h0
`define DBS_ORG_CODE_X18  2'h1
`define DBS_ORG_CODE_X36  2'h2

// ----------------------------------------------------------------------------
// address lines decoded per organisation
// ----------------------------------------------------------------------------
`define DBS_X8_ADDR_LINES  20
`define DBS_X18_ADDR_LINES 20
`define DBS_X36_ADDR_LINES 19

`endif

// ### include/dbs_pkg.sv
// types shared by the burst sram front end
`include "dbs_defs.svh"

package dbs_pkg;

  // ----------------------------------------------------------------------------
  // array organisation selected by strap
  // ----------------------------------------------------------------------------
  typedef enum logic [`DBS_ORG_W-1:0] {
    DBS_ORG_X8  = `DBS_ORG_CODE_X8,
    DBS_ORG_X18 = `DBS_ORG_CODE_X18,
    DBS_ORG_X36 = `DBS_ORG_CODE_X36
  } dbs_org_t;

  typedef logic [`DBS_IADDR_W-1:0] dbs_iaddr_t;
  typedef logic [`DBS_DATA_W-1:0]  dbs_data_t;

endpackage

// ### tb/dbs_ctl_model.sv
// controller model: pin clocks and command driver
`timescale 1ns/100ps

module dbs_ctl_model
  import dbs_pkg::*;
(
  // system clock and clock mode
  input  wire logic mclk,
  input  wire logic out_clk_present,
  // pin clocks
  output logic      k_clk,
  output logic      k_clk_n,
  output logic      c_clk,
  output logic      c_clk_n,
  // command and data pins
  output logic [19:0] addr_pin,
  output logic        load_strobe_n,
  output logic        rd_wr_dir,
  output logic [35:0] dq_in,
  output logic [3:0]  byte_lane_mask_n
);
  logic [3:0] cnt = 4'h0;

  // sixteen mclk per period so each level outlasts the synchronisers
  always @(posedge mclk)
    cnt <= #1 cnt + 4'h1;

  assign k_clk = ~cnt[3];
  assign k_clk_n = cnt[3];
  // output pair lags a quarter period, held low in single clock mode
  assign c_clk = out_clk_present & (cnt[3] ^ cnt[2]);
  assign c_clk_n = out_clk_present & ~(cnt[3] ^ cnt[2]);

  initial
  begin
    load_strobe_n = 1'b1;
    rd_wr_dir = 1'b0;
    addr_pin = 20'h0_0000;
    dq_in = 36'h0_0000_0000;
    byte_lane_mask_n = 4'hf;
  end

  // one period: command and first beat around k rise, second beat around k_n rise
  task automatic per(logic ld_n, logic dir, logic [19:0] a, logic [35:0] d0, d1, logic [3:0] m0, m1);
    @(posedge mclk iff cnt == 4'hb);
    #1;
    load_strobe_n = ld_n;
    rd_wr_dir = dir;
    addr_pin = a;
    dq_in = d0;
    byte_lane_mask_n = m0;
    @(posedge mclk iff cnt == 4'h3);
    #1;
    // released lines show the inverse rather than a stale value
    load_strobe_n = 1'b1;
    rd_wr_dir = ~dir;
    addr_pin = ~a;
    dq_in = d1;
    byte_lane_mask_n = m1;
  endtask
endmodule // dbs_ctl_model

// ### tb/dbs_port_sva.sv
// assertion checker for the burst sram port pins
`timescale 1ns/100ps

module dbs_port_sva
  import dbs_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // pin clocks and straps
  input wire logic        k_clk,
  input wire logic        k_clk_n,
  input wire logic        c_clk,
  input wire logic        c_clk_n,
  input wire logic        out_clk_present,
  input wire logic [1:0]  org_sel,
  // command and read pins
  input wire logic        load_strobe_n,
  input wire logic        rd_wr_dir,
  input wire logic [35:0] dq_out,
  input wire logic        dq_oe
);
  // --------
  // helpers
  // --------
  logic [2:0] k_r, kn_r, c_r, cn_r;
  logic [1:0] ld_r, dir_r;
  logic [5:0] rd_age_r, l_age_r, idle_r;
  logic       kr, lr;

  // two flops like the port, a third to find edges
  always_ff @(posedge mclk)
  begin
    k_r <= {k_r[1:0], k_clk};
    kn_r <= {kn_r[1:0], k_clk_n};
    c_r <= {c_r[1:0], c_clk};
    cn_r <= {cn_r[1:0], c_clk_n};
    ld_r <= {ld_r[0], load_strobe_n};
    dir_r <= {dir_r[0], rd_wr_dir};
  end

  assign kr = k_r[1] & ~k_r[2];
  assign lr = out_clk_present ? (c_r[1] & ~c_r[2]) | (cn_r[1] & ~cn_r[2]) : kr | (kn_r[1] & ~kn_r[2]);

  // ages saturate so an old event never wraps back to young
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rd_age_r <= 6'h3f;
      l_age_r <= 6'h3f;
      idle_r <= 6'h00;
    end
    else
    begin
      rd_age_r <= (kr & ~ld_r[1] & dir_r[1]) ? 6'h00 : rd_age_r + {5'h00, rd_age_r != 6'h3f};
      l_age_r <= lr ? 6'h00 : l_age_r + {5'h00, l_age_r != 6'h3f};
      idle_r <= !load_strobe_n ? 6'h00 : idle_r + {5'h00, idle_r != 6'h3f};
    end
  end

  // --------
  // properties
  // --------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence rd_load_s; kr && !ld_r[1] && dir_r[1]; endsequence
  sequence wr_load_s; kr && !ld_r[1] && !dir_r[1]; endsequence
  sequence oe_soon_s; ##[1:40] dq_oe; endsequence

  rst_quiet_a: assert property ($rose(nrst) |-> !dq_oe && dq_out == '0) else $error("drive after reset");
  rd_drive_a: assert property (rd_load_s |-> oe_soon_s) else $error("read load not driven");
  oe_cause_a: assert property ($rose(dq_oe) |-> rd_age_r < 6'h28) else $error("drive without read");
  idle_off_a: assert property (idle_r > 6'h28 |-> !dq_oe) else $error("drive while idle");
  launch_only_a: assert property ($changed(dq_out) |-> lr || l_age_r < 6'h04) else $error("data off launch");
  x8_zero_a: assert property ($changed(dq_out) && org_sel == 2'h0 && $past(org_sel, 8) == 2'h0
    |-> dq_out[35:8] == '0) else $error("narrow word has high bits");
  x18_zero_a: assert property ($changed(dq_out) && org_sel == 2'h1 && $past(org_sel, 8) == 2'h1
    |-> dq_out[35:18] == '0) else $error("mid word has high bits");
  wr_quiet_a: assert property (wr_load_s ##0 (!dq_oe && rd_age_r > 6'h28) |=> (!dq_oe) [*8])
    else $error("write drove data");
endmodule // dbs_port_sva

bind dbs_sram_port dbs_port_sva i_dbs_port_sva
(
  .mclk            (mclk),
  .nrst            (nrst),
  .k_clk           (k_clk),
  .k_clk_n         (k_clk_n),
  .c_clk           (c_clk),
  .c_clk_n         (c_clk_n),
  .out_clk_present (out_clk_present),
  .org_sel         (org_sel),
  .load_strobe_n   (load_strobe_n),
  .rd_wr_dir       (rd_wr_dir),
  .dq_out          (dq_out),
  .dq_oe           (dq_oe)
);

// ### tb/tb_top.sv
// self-checking bench for the burst sram port
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    checks_done++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, a, e); \
    end \
  end

module tb_top
  import dbs_pkg::*;
;
  logic        mclk = 1'b0;
  logic        nrst, out_clk_present, k_clk, k_clk_n, c_clk, c_clk_n, load_strobe_n, rd_wr_dir, dq_oe;
  logic [1:0]  org_sel;
  logic [19:0] addr_pin;
  logic [19:0] ad [4];
  logic [35:0] dq_in, dq_out, pd0, pd1;
  logic [35:0] mem [1024];
  logic [3:0]  byte_lane_mask_n, pm0, pm1;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          seed = 32'h7551_3421;

  always #2.5 mclk = ~mclk;

  dbs_sram_port i_dbs_sram_port (.*);
  dbs_ctl_model ctl (.*);

  // -------------
  // expectations
  // -------------
  function automatic logic [35:0] r36();
    return {4'($random(seed)), 32'($random(seed))};
  endfunction

  function automatic logic [9:0] idx(logic [19:0] a, logic b);
    return (org_sel == 2'h0) ? {a[8:0], b} : a[9:0] ^ {9'h000, b};
  endfunction

  // enabled bits of a word, trimmed to the organisation width
  function automatic logic [35:0] lanes(logic [3:0] mk);
    logic [35:0] en;
    en = {{9{~mk[3]}}, {9{~mk[2]}}, {9{~mk[1]}}, {9{~mk[0]}}};
    if (org_sel == 2'h0)
      en = {28'h000_0000, {4{~mk[1]}}, {4{~mk[0]}}};
    return en & (org_sel == 2'h1 ? 36'h0_0003_ffff : 36'hf_ffff_ffff);
  endfunction

  // -------------
  // stimulus tasks
  // -------------
  task automatic at(logic [3:0] n);
    @(posedge mclk iff ctl.cnt == n);
    #1;
  endtask

  // strobe high with random address, direction and enabled data: nothing may land
  task automatic idle();
    ctl.per(1'b1, 1'($random(seed)), 20'($random(seed)), r36(), r36(), 4'h0, 4'h0);
  endtask

  // data owed to the previous write load rides this period
  task automatic wstep(logic ld_n, logic [19:0] a, logic [3:0] m0, logic [3:0] m1);
    ctl.per(ld_n, 1'b0, a, pd0, pd1, pm0, pm1);
    pd0 = r36();
    pd1 = r36();
    pm0 = m0;
    pm1 = m1;
    if (!ld_n)
    begin
      mem[idx(a, 1'b0)] = (mem[idx(a, 1'b0)] & ~lanes(m0)) | (pd0 & lanes(m0));
      mem[idx(a, 1'b1)] = (mem[idx(a, 1'b1)] & ~lanes(m1)) | (pd1 & lanes(m1));
    end
  endtask

  task automatic rd(logic [19:0] a, logic [19:0] ea);
    logic [35:0] e0, e1;
    e0 = mem[idx(ea, 1'b0)] & lanes(4'h0);
    e1 = mem[idx(ea, 1'b1)] & lanes(4'h0);
    ctl.per(1'b0, 1'b1, a, r36(), r36(), 4'h0, 4'h0);
    if (out_clk_present)
    begin
      at(4'ha);
      `CHK(dq_out, e0)
    end
    idle();
    `CHK(dq_oe, 1'b1)
    `CHK(dq_out, out_clk_present ? e1 : e0)
    if (!out_clk_present)
    begin
      at(4'hb);
      `CHK(dq_out, e1)
    end
  endtask

  task automatic results();
    $display("TB: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // -------------
  // main sequence
  // -------------
  initial
  begin
    nrst = 1'b0;
    out_clk_present = 1'b1;
    org_sel = 2'h0;
    pd0 = 36'h0_0000_0000;
    pd1 = 36'h0_0000_0000;
    pm0 = 4'h0;
    pm1 = 4'h0;
    repeat (4) @(posedge mclk);
    #1;
    nrst = 1'b1;
    // every organisation, spare strap code too, in both clock modes
    for (int o = 0; o < 8; o++)
    begin
      org_sel = 2'(o >> 1);
      out_clk_present = o[0];
      repeat (3) idle();
      `CHK(dq_oe, 1'b0)
      for (int i = 0; i < 4; i++)
      begin
        ad[i] = (i == 3) ? {20{o[0]}} : 20'($random(seed));
        wstep(1'b0, ad[i], 4'h0, 4'h0);
      end
      wstep(1'b0, ad[0], 4'($random(seed)), 4'($random(seed)));
      wstep(1'b1, 20'($random(seed)), 4'h0, 4'h0);
      idle();
      `CHK(dq_oe, 1'b0)
      // wide organisations ignore the top address line
      for (int i = 0; i < 4; i++)
        rd(ad[i] ^ (org_sel[1] ? 20'h8_0000 : 20'h0_0000), ad[i]);
      repeat (3) idle();
      `CHK(dq_oe, 1'b0)
    end
    results();
  end

  // hang guard, far beyond the few thousand cycles the run needs
  initial
  begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule // tb_top
